//--- design/psw_core_pkg.sv
/*
 * constants for the status word and instruction side-effect block:
 * register offsets, command codes, flag positions, reset values.
 * assumes a single 32-bit AHB-Lite slave port in front of the block.
 */
package psw_core_pkg;

	// ****************************************
	// widths
	// ****************************************
	localparam int DATA_W = 8;
	localparam int WIDE_W = 16;
	localparam int OFFS_W = 8;
	localparam int OP_W = 4;
	localparam int BSEL_W = 3;
	localparam int DCNT_W = 5;

	// ****************************************
	// register byte offsets
	// ****************************************
	localparam logic [OFFS_W-1:0] OFFS_CMD = 8'h00;
	localparam logic [OFFS_W-1:0] OFFS_OPND_A = 8'h04;
	localparam logic [OFFS_W-1:0] OFFS_OPND_B = 8'h08;
	localparam logic [OFFS_W-1:0] OFFS_STATUS = 8'h0C;
	localparam logic [OFFS_W-1:0] OFFS_RESULT = 8'h10;
	localparam logic [OFFS_W-1:0] OFFS_IRQ_REQ = 8'h14;
	localparam logic [OFFS_W-1:0] OFFS_DIR = 8'h18;
	localparam logic [OFFS_W-1:0] OFFS_BRANCH = 8'h1C;

	// ****************************************
	// command field layout (cmd register)
	// ****************************************
	localparam int CMD_OP_LSB = 0;
	localparam int CMD_BSEL_LSB = 4;

	// ****************************************
	// command codes
	// ****************************************
	localparam logic [OP_W-1:0] OP_ADD_CARRY = 4'h0;
	localparam logic [OP_W-1:0] OP_SUBTRACT_BORROW = 4'h1;
	localparam logic [OP_W-1:0] OP_CARRY_SET = 4'h2;
	localparam logic [OP_W-1:0] OP_CARRY_CLEAR = 4'h3;
	localparam logic [OP_W-1:0] OP_BCD_SET = 4'h4;
	localparam logic [OP_W-1:0] OP_BCD_CLEAR = 4'h5;
	localparam logic [OP_W-1:0] OP_XMODE_SET = 4'h6;
	localparam logic [OP_W-1:0] OP_XMODE_CLEAR = 4'h7;
	localparam logic [OP_W-1:0] OP_PRODUCT = 4'h8;
	localparam logic [OP_W-1:0] OP_QUOTIENT = 4'h9;
	localparam logic [OP_W-1:0] OP_BRANCH_ON_BIT_CLEAR = 4'hA;
	localparam logic [OP_W-1:0] OP_BRANCH_ON_BIT_SET = 4'hB;
	localparam logic [OP_W-1:0] OP_DIR_BIT_TEST = 4'hC;
	localparam logic [OP_W-1:0] OP_MEM_IMMEDIATE_STORE = 4'hD;
	localparam logic [OP_W-1:0] OP_NOP = 4'hF;

	// ****************************************
	// status word bit positions
	// ****************************************
	localparam int PSW_C = 0;
	localparam int PSW_Z = 1;
	localparam int PSW_I = 2;
	localparam int PSW_D = 3;
	localparam int PSW_B = 4;
	localparam int PSW_T = 5;
	localparam int PSW_V = 6;
	localparam int PSW_N = 7;

	// ****************************************
	// reset values and constants
	// ****************************************
	localparam logic [DATA_W-1:0] PSW_RESET = 8'h04;
	localparam logic [DATA_W-1:0] BYTE_ZERO = 8'h00;
	localparam logic [WIDE_W-1:0] WIDE_ZERO = 16'h0000;
	localparam logic [31:0] WORD_ZERO = 32'h0000_0000;
	localparam logic [3:0] BCD_MAX = 4'h9;
	localparam logic [4:0] BCD_ADJ = 5'h06;
	localparam logic [DCNT_W-1:0] DIV_STEPS = 5'h10;
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	localparam logic HRESP_OKAY = 1'b0;

endpackage

//--- design/bcd_digit.sv
/*
 * one decimal digit of add-with-carry / subtract-with-borrow.
 * assumes valid bcd inputs; carry in/out is "no borrow" when subtracting.
 */
`timescale 1ns/1ns
`default_nettype none
module bcd_digit
	import psw_core_pkg::*;
(
	input wire logic [3:0] a,
	input wire logic [3:0] b,
	input wire logic carry_in,
	input wire logic subtract,
	output logic [3:0] digit,
	output logic carry_out
);
	logic [4:0] raw;

	always_comb begin
		raw = 5'h00;
		digit = 4'h0;
		carry_out = 1'b0;
		if (subtract) begin
			raw = {1'b0, a} - {1'b0, b} - {4'h0, ~carry_in};
			// borrow out of the digit: step back by six
			if (raw[4]) begin
				digit = 4'(raw - BCD_ADJ);
				carry_out = 1'b0;
			end else begin
				digit = raw[3:0];
				carry_out = 1'b1;
			end
		end else begin
			raw = {1'b0, a} + {1'b0, b} + {4'h0, carry_in};
			if (raw > {1'b0, BCD_MAX}) begin
				digit = 4'(raw + BCD_ADJ);
				carry_out = 1'b1;
			end else begin
				digit = raw[3:0];
				carry_out = 1'b0;
			end
		end
	end
endmodule
`default_nettype wire

//--- design/psw_core.sv
/*
 * status word and instruction side effects of the 8-bit core, run as
 * commands written over an AHB-Lite slave port.
 * assumes one slave on the bus (hready is this block's hreadyout) and
 * whole-word single transfers.
 */
// Operation
// - reset forces the interrupt mask flag to one; other flags cleared to zero.
// - bit tests see a written interrupt request only after one more command.
// - decimal flag makes add and subtract decimal; carry/decimal ops follow.
// - after decimal arithmetic only carry is meaningful; N, V, Z undefined.
// - multiply and divide ignore the index-x flag and decimal flag.
// - multiply and divide leave the whole status word unchanged.
// - direction register reads never return the stored direction value.
`timescale 1ns/1ns
`default_nettype none
module psw_core
	import psw_core_pkg::*;
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	input wire logic [DATA_W-1:0] irq_event,
	output logic hreadyout,
	output logic [31:0] hrdata,
	output logic hresp,
	output logic [DATA_W-1:0] processor_status_word,
	output logic [DATA_W-1:0] dir_out
);
	// ****************************************
	// state
	// ****************************************
	typedef enum logic [0:0] {EX_IDLE, EX_DIVIDE} exec_t;

	typedef struct packed {
		logic dp_valid;
		logic dp_write;
		logic [OFFS_W-1:0] dp_addr;
		logic hreadyout;
		logic [31:0] hrdata;
		logic hresp;
		exec_t exec;
		logic [DCNT_W-1:0] div_count;
		logic [DATA_W-1:0] div_rem;
		logic [WIDE_W-1:0] div_dvd;
		logic [DATA_W-1:0] psw;
		logic [WIDE_W-1:0] opnd_a;
		logic [DATA_W-1:0] opnd_b;
		logic [WIDE_W-1:0] result;
		logic [DATA_W-1:0] irq_req;
		logic [DATA_W-1:0] irq_view;
		logic [DATA_W-1:0] dir;
		logic taken;
	} state_t;

	state_t state_reg;
	state_t state_next;

	// ****************************************
	// decimal datapath
	// ****************************************
	logic [OP_W-1:0] wr_op;
	logic op_is_sub;
	logic [3:0] bcd_lo;
	logic [3:0] bcd_hi;
	logic bcd_mid_carry;
	logic bcd_carry;

	assign wr_op = hwdata[CMD_OP_LSB +: OP_W];
	assign op_is_sub = (wr_op == OP_SUBTRACT_BORROW);

	bcd_digit u_bcd_lo (
		.a(state_reg.opnd_a[3:0]),
		.b(state_reg.opnd_b[3:0]),
		.carry_in(state_reg.psw[PSW_C]),
		.subtract(op_is_sub),
		.digit(bcd_lo),
		.carry_out(bcd_mid_carry)
	);

	bcd_digit u_bcd_hi (
		.a(state_reg.opnd_a[7:4]),
		.b(state_reg.opnd_b[7:4]),
		.carry_in(bcd_mid_carry),
		.subtract(op_is_sub),
		.digit(bcd_hi),
		.carry_out(bcd_carry)
	);

	// ****************************************
	// next state
	// ****************************************
	always_comb begin
		logic complete;
		logic accept;
		logic [BSEL_W-1:0] bsel;
		logic [DATA_W:0] bin_sum;
		logic [DATA_W-1:0] b_eff;
		logic [DATA_W:0] rem_shift;
		logic [31:0] rd;
		complete = 1'b0;
		accept = 1'b0;
		bsel = hwdata[CMD_BSEL_LSB +: BSEL_W];
		bin_sum = 9'h000;
		b_eff = BYTE_ZERO;
		rem_shift = 9'h000;
		rd = WORD_ZERO;
		state_next = state_reg;
		state_next.hresp = HRESP_OKAY;
		// hardware request events: set wins over a software write
		state_next.irq_req = state_reg.irq_req | irq_event;

		// iterative divide, restoring, one quotient bit per cycle
		if (state_reg.exec == EX_DIVIDE) begin
			rem_shift = {state_reg.div_rem, state_reg.div_dvd[WIDE_W-1]};
			state_next.div_dvd = {state_reg.div_dvd[WIDE_W-2:0], 1'b0};
			if (rem_shift >= {1'b0, state_reg.opnd_b}) begin
				state_next.div_rem = 8'(rem_shift - {1'b0, state_reg.opnd_b});
				state_next.div_dvd[0] = 1'b1;
			end else begin
				state_next.div_rem = rem_shift[DATA_W-1:0];
			end
			state_next.div_count = state_reg.div_count - 5'h01;
			if (state_reg.div_count == 5'h01) begin
				state_next.exec = EX_IDLE;
				// quotient low, remainder high; psw untouched
				state_next.result = {state_next.div_rem,
					state_next.div_dvd[DATA_W-1:0]};
			end
		end

		complete = state_reg.dp_valid && state_reg.hreadyout;
		if (complete) begin
			state_next.dp_valid = 1'b0;
			state_next.hreadyout = 1'b1;
		end
		if (complete && state_reg.dp_write) begin
			case (state_reg.dp_addr)
				OFFS_CMD: begin
					// the tested view catches up after each command
					state_next.irq_view = state_reg.irq_req;
					case (wr_op)
						OP_ADD_CARRY, OP_SUBTRACT_BORROW: begin
							if (state_reg.psw[PSW_D]) begin
								state_next.result = {BYTE_ZERO, bcd_hi, bcd_lo};
								// n, v, z left as they were
								state_next.psw[PSW_C] = bcd_carry;
							end else begin
								b_eff = op_is_sub ? ~state_reg.opnd_b : state_reg.opnd_b;
								bin_sum = {1'b0, state_reg.opnd_a[DATA_W-1:0]} +
									{1'b0, b_eff} + {8'h00, state_reg.psw[PSW_C]};
								state_next.result = {BYTE_ZERO, bin_sum[DATA_W-1:0]};
								state_next.psw[PSW_C] = bin_sum[DATA_W];
								state_next.psw[PSW_Z] = (bin_sum[DATA_W-1:0] == BYTE_ZERO);
								state_next.psw[PSW_N] = bin_sum[DATA_W-1];
								state_next.psw[PSW_V] =
									(state_reg.opnd_a[DATA_W-1] ^ bin_sum[DATA_W-1]) &
									(b_eff[DATA_W-1] ^ bin_sum[DATA_W-1]);
							end
						end
						// flag ops are correct even straight after arithmetic
						OP_CARRY_SET: state_next.psw[PSW_C] = 1'b1;
						OP_CARRY_CLEAR: state_next.psw[PSW_C] = 1'b0;
						OP_BCD_SET: state_next.psw[PSW_D] = 1'b1;
						OP_BCD_CLEAR: state_next.psw[PSW_D] = 1'b0;
						OP_XMODE_SET: state_next.psw[PSW_T] = 1'b1;
						OP_XMODE_CLEAR: state_next.psw[PSW_T] = 1'b0;
						OP_PRODUCT: begin
							// no t or d term, no psw write
							state_next.result = 16'(state_reg.opnd_a[DATA_W-1:0] *
								state_reg.opnd_b);
						end
						OP_QUOTIENT: begin
							state_next.exec = EX_DIVIDE;
							state_next.div_count = DIV_STEPS;
							state_next.div_rem = BYTE_ZERO;
							state_next.div_dvd = state_reg.opnd_a;
						end
						OP_BRANCH_ON_BIT_CLEAR: begin
							state_next.taken = ~state_reg.irq_view[bsel];
						end
						OP_BRANCH_ON_BIT_SET: begin
							state_next.taken = state_reg.irq_view[bsel];
						end
						// direction storage is not on any read path
						OP_DIR_BIT_TEST: state_next.taken = 1'b0;
						OP_MEM_IMMEDIATE_STORE: begin
							state_next.dir = state_reg.opnd_b;
						end
						default: begin
						end
					endcase
				end
				OFFS_OPND_A: state_next.opnd_a = hwdata[WIDE_W-1:0];
				OFFS_OPND_B: state_next.opnd_b = hwdata[DATA_W-1:0];
				OFFS_STATUS: state_next.psw = hwdata[DATA_W-1:0];
				OFFS_IRQ_REQ: state_next.irq_req = hwdata[DATA_W-1:0] | irq_event;
				OFFS_DIR: state_next.dir = hwdata[DATA_W-1:0];
				default: begin
				end
			endcase
		end

		// one wait state on every transfer; longer while dividing
		if (state_reg.dp_valid && !state_reg.hreadyout &&
			state_reg.exec == EX_IDLE) begin
			case (state_reg.dp_addr)
				OFFS_STATUS: rd = {24'h00_0000, state_reg.psw};
				OFFS_OPND_A: rd = {16'h0000, state_reg.opnd_a};
				OFFS_OPND_B: rd = {24'h00_0000, state_reg.opnd_b};
				OFFS_RESULT: rd = {16'h0000, state_reg.result};
				OFFS_IRQ_REQ: rd = {24'h00_0000, state_reg.irq_req};
				OFFS_DIR: rd = WORD_ZERO;
				OFFS_BRANCH: rd = {31'h0000_0000, state_reg.taken};
				default: rd = WORD_ZERO;
			endcase
			state_next.hrdata = rd;
			state_next.hreadyout = 1'b1;
		end

		accept = hsel && hready && (htrans == HTRANS_NONSEQ);
		if (accept) begin
			state_next.dp_valid = 1'b1;
			state_next.dp_write = hwrite;
			state_next.dp_addr = haddr[OFFS_W-1:0];
			state_next.hreadyout = 1'b0;
		end
	end

	// ****************************************
	// registers
	// ****************************************
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_reg <= '{dp_valid: 1'b0, dp_write: 1'b0, dp_addr: 8'h00,
				hreadyout: 1'b1, hrdata: 32'h0000_0000, hresp: 1'b0,
				exec: EX_IDLE, div_count: 5'h00, div_rem: 8'h00,
				div_dvd: 16'h0000, psw: PSW_RESET, opnd_a: 16'h0000,
				opnd_b: 8'h00, result: 16'h0000, irq_req: 8'h00,
				irq_view: 8'h00, dir: 8'h00, taken: 1'b0};
		end else begin
			state_reg <= state_next;
		end
	end

	assign hreadyout = state_reg.hreadyout;
	assign hrdata = state_reg.hrdata;
	assign hresp = state_reg.hresp;
	assign processor_status_word = state_reg.psw;
	assign dir_out = state_reg.dir;

endmodule
`default_nettype wire

//--- verif/psw_core_assertions.sv
/*
 * concurrent checks on the ports of psw_core.
 * assumes bind from the bench top; hready is the slave's own hreadyout.
 */
`timescale 1ns/1ns
`default_nettype none
module psw_core_assertions
	import psw_core_pkg::*;
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	input wire logic hreadyout,
	input wire logic [31:0] hrdata,
	input wire logic hresp,
	input wire logic [DATA_W-1:0] processor_status_word,
	input wire logic [DATA_W-1:0] dir_out
);
	// ****************************************
	// data phase tracking
	// ****************************************
	logic taken, done, pend, pend_wr;
	logic [7:0] pend_addr;
	assign taken = hsel && hready && htrans == HTRANS_NONSEQ;
	assign done = pend && hready;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pend <= 1'b0;
			pend_wr <= 1'b0;
			pend_addr <= 8'h00;
		end else if (taken) begin
			pend <= 1'b1;
			pend_wr <= hwrite;
			pend_addr <= haddr[7:0];
		end else if (hready) begin
			pend <= 1'b0;
		end
	end
	// ****************************************
	// assertions
	// ****************************************
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	reset_mask_a: assert property (
		$rose(hresetn) |-> processor_status_word == PSW_RESET)
		else $error("status word wrong after reset");
	okay_resp_a: assert property (hresp == HRESP_OKAY)
		else $error("response not okay");
	wait_bound_a: assert property (
		taken |=> !hreadyout ##[1:17] hreadyout)
		else $error("data phase length wrong");
	md_psw_hold_a: assert property (
		done && pend_wr && pend_addr == OFFS_CMD &&
		(hwdata[CMD_OP_LSB +: OP_W] == OP_PRODUCT ||
		hwdata[CMD_OP_LSB +: OP_W] == OP_QUOTIENT)
		|=> $stable(processor_status_word) [*2])
		else $error("multiply or divide changed status");
	dir_read_zero_a: assert property (
		done && !pend_wr && pend_addr == OFFS_DIR
		|-> hrdata == WORD_ZERO)
		else $error("direction value readable");
	dir_store_a: assert property (
		done && pend_wr && pend_addr == OFFS_DIR
		|=> dir_out == $past(hwdata[DATA_W-1:0]))
		else $error("direction store lost");
	dir_hold_a: assert property (
		!(done && pend_wr &&
		(pend_addr == OFFS_DIR || pend_addr == OFFS_CMD))
		|=> $stable(dir_out))
		else $error("direction changed unasked");
	status_load_a: assert property (
		done && pend_wr && pend_addr == OFFS_STATUS
		|=> processor_status_word == $past(hwdata[DATA_W-1:0]))
		else $error("status load lost");
	unmapped_zero_a: assert property (
		done && !pend_wr && pend_addr >= 8'h20
		|-> hrdata == WORD_ZERO)
		else $error("unmapped read not zero");
	dir_read_c: cover property (done && !pend_wr && pend_addr == OFFS_DIR);
	divide_wait_c: cover property (!hreadyout [*5]);
	product_c: cover property (done && pend_wr && pend_addr == OFFS_CMD &&
		hwdata[CMD_OP_LSB +: OP_W] == OP_PRODUCT);
endmodule
`default_nettype wire

//--- verif/tb_top.sv
/*
 * self-checking bench for psw_core, driving its AHB-Lite port directly.
 * assumes the checker module is compiled beforehand.
 */
`timescale 1ns/1ns
`default_nettype none
module tb_top
	import psw_core_pkg::*;
;
	logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
	logic [31:0] haddr = 32'h0000_0000, hwdata = 32'h0000_0000, hrdata;
	logic [1:0] htrans = 2'h0;
	logic [7:0] irq_event = 8'h00, psw, dir_out;
	logic hreadyout, hresp;
	logic [31:0] r;
	int err_count = 0, checks = 0;
	always #5 hclk = ~hclk;
	psw_core uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
		.hwdata(hwdata), .hready(hreadyout), .irq_event(irq_event),
		.hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
		.processor_status_word(psw), .dir_out(dir_out));
	// ****************************************
	// bus and check tasks
	// ****************************************
	task conclude();
		if (err_count == 0 && checks > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	task chk(input string name, input logic [31:0] seen,
		input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			err_count++;
			$display("mismatch %s expected %h seen %h", name, exp, seen);
		end
	endtask
	// bounded: a hung hreadyout ends the run as a failure
	task wait_rdy(output logic [31:0] d);
		logic rdy;
		rdy = 1'b0;
		for (int n = 0; n < 40 && !rdy; n++) begin
			#1;
			rdy = (hreadyout === 1'b1);
			d = hrdata;
			@(posedge hclk);
		end
		if (!rdy) begin
			err_count++;
			conclude();
		end
	endtask
	task xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q);
		hsel <= 1'b1;
		htrans <= HTRANS_NONSEQ;
		haddr <= {24'h00_0000, a};
		hwrite <= w;
		wait_rdy(q);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		wait_rdy(q);
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		xfer(1'b1, a, d, r);
	endtask
	task cmd(input logic [3:0] op, input logic [2:0] bs);
		wr(OFFS_CMD, {25'h000_0000, bs, op});
	endtask
	task rd(input logic [7:0] a);
		xfer(1'b0, a, 32'h0000_0000, r);
	endtask
	// flags written at the last edge only show in the next time step
	task settle();
		@(posedge hclk);
	endtask
	// ****************************************
	// scenarios
	// ****************************************
	task t_decimal();
		wr(OFFS_STATUS, 32'h0000_0008);
		wr(OFFS_OPND_A, 32'h0000_0019);
		wr(OFFS_OPND_B, 32'h0000_0028);
		cmd(OP_ADD_CARRY, 3'h0);
		rd(OFFS_RESULT);
		chk("bcd sum", {r[7:0], 7'h00, psw[PSW_C]}, 16'h4700);
		wr(OFFS_OPND_A, 32'h0000_0099);
		wr(OFFS_OPND_B, 32'h0000_0001);
		cmd(OP_ADD_CARRY, 3'h0);
		rd(OFFS_RESULT);
		chk("bcd wrap", {r[7:0], 7'h00, psw[PSW_C]}, 16'h0001);
		cmd(OP_CARRY_CLEAR, 3'h0);
		settle();
		chk("carry clear", psw[PSW_C], 1'b0);
		cmd(OP_CARRY_SET, 3'h0);
		wr(OFFS_OPND_A, 32'h0000_0042);
		wr(OFFS_OPND_B, 32'h0000_0015);
		cmd(OP_SUBTRACT_BORROW, 3'h0);
		rd(OFFS_RESULT);
		chk("bcd diff", {r[7:0], 7'h00, psw[PSW_C]}, 16'h2701);
		cmd(OP_BCD_CLEAR, 3'h0);
		cmd(OP_CARRY_CLEAR, 3'h0);
		wr(OFFS_OPND_A, 32'h0000_007F);
		wr(OFFS_OPND_B, 32'h0000_0001);
		cmd(OP_ADD_CARRY, 3'h0);
		rd(OFFS_RESULT);
		chk("binary sum", {r[7:0], psw}, 16'h80C0);
	endtask
	task t_muldiv();
		for (int p = 0; p < 2; p++) begin
			wr(OFFS_STATUS, 32'h0000_0000);
			if (p == 0) cmd(OP_BCD_SET, 3'h0);
			if (p == 0) cmd(OP_XMODE_SET, 3'h0);
			if (p == 1) cmd(OP_XMODE_CLEAR, 3'h0);
			wr(OFFS_OPND_A, 32'h0000_00C8);
			wr(OFFS_OPND_B, 32'h0000_000D);
			cmd(OP_PRODUCT, 3'h0);
			rd(OFFS_RESULT);
			chk("product", r, 32'h0000_0A28);
			chk("psw after product", psw, p == 0 ? 8'h28 : 8'h00);
			wr(OFFS_OPND_A, 32'h0000_0100);
			wr(OFFS_OPND_B, 32'h0000_0007);
			cmd(OP_QUOTIENT, 3'h0);
			rd(OFFS_RESULT);
			chk("quotient", r, 32'h0000_0424);
			chk("psw after divide", psw, p == 0 ? 8'h28 : 8'h00);
		end
	endtask
	task t_irq();
		wr(OFFS_IRQ_REQ, 32'h0000_0010);
		cmd(OP_BRANCH_ON_BIT_SET, 3'h4);
		rd(OFFS_BRANCH);
		chk("test without gap", r, 32'h0000_0000);
		cmd(OP_NOP, 3'h0);
		cmd(OP_BRANCH_ON_BIT_SET, 3'h4);
		rd(OFFS_BRANCH);
		chk("set test after gap", r, 32'h0000_0001);
		irq_event <= 8'h02;
		@(posedge hclk);
		irq_event <= 8'h00;
		cmd(OP_NOP, 3'h0);
		cmd(OP_BRANCH_ON_BIT_CLEAR, 3'h1);
		rd(OFFS_BRANCH);
		chk("clear test on event", r, 32'h0000_0000);
		cmd(OP_BRANCH_ON_BIT_CLEAR, 3'h0);
		rd(OFFS_BRANCH);
		chk("clear test on zero", r, 32'h0000_0001);
		rd(OFFS_IRQ_REQ);
		chk("request word", r, 32'h0000_0012);
	endtask
	task t_dir();
		wr(OFFS_DIR, 32'h0000_00A5);
		settle();
		chk("dir store", dir_out, 8'hA5);
		rd(OFFS_DIR);
		chk("dir read", r, 32'h0000_0000);
		// leave taken at one so the direction test must clear it
		cmd(OP_BRANCH_ON_BIT_CLEAR, 3'h0);
		cmd(OP_DIR_BIT_TEST, 3'h0);
		rd(OFFS_BRANCH);
		chk("dir bit test", r, 32'h0000_0000);
		wr(OFFS_OPND_B, 32'h0000_003C);
		cmd(OP_MEM_IMMEDIATE_STORE, 3'h0);
		settle();
		chk("dir immediate", dir_out, 8'h3C);
		wr(8'h20, 32'h0000_00FF);
		rd(8'h20);
		chk("unmapped", r, 32'h0000_0000);
	endtask
	task t_reset();
		hresetn <= 1'b0;
		@(posedge hclk);
		#1;
		chk("psw in reset", {psw, dir_out}, {PSW_RESET, 8'h00});
		@(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		rd(OFFS_STATUS);
		chk("status after reset", r, {24'h00_0000, PSW_RESET});
	endtask
	initial begin
		repeat (5) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		chk("psw after reset", psw, PSW_RESET);
		t_decimal();
		t_muldiv();
		t_irq();
		t_dir();
		t_reset();
		conclude();
	end
endmodule
bind psw_core psw_core_assertions chk_i (.hclk(hclk), .hresetn(hresetn),
	.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
	.hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
	.hrdata(hrdata), .hresp(hresp),
	.processor_status_word(processor_status_word), .dir_out(dir_out));
`default_nettype wire
